// ---- rtl/psi_defines.vh ----
// Constants of the serial slave port of the power controller.
`ifndef PSI_DEFINES_VH
`define PSI_DEFINES_VH
`define PSI_ADDR_BASE 7'h20
`define PSI_ADDR_BCAST 7'h40
`define PSI_ADDR_ARA 7'h0c
`define PSI_REG_INT 8'h00
`define PSI_REG_INTMASK 8'h01
`define PSI_REG_CONFIG 8'h0a
`define PSI_REG_PBGLOBAL 8'h0b
`define PSI_PORT_LO 4'h1
`define PSI_PORT_HI 4'h4
`define PSI_PWR_LO 4'h4
`define PSI_PWR_HI 4'h7
`define PSI_MEAS_LO 4'h9
`define PSI_MEAS_HI 4'hc
`define PSI_BITS_BYTE 4'h8
`define PSI_BIT_LAST 4'h7
`endif

// ---- rtl/psi_regmem.v ----
// Register store holding one full register set for each virtual quad.
`timescale 1ns/100ps
module psi_regmem (
  input wire mclk_i,
  input wire wr_en_i,
  input wire [8:0] wr_addr_i,
  input wire [7:0] wr_data_i,
  input wire [8:0] rd_addr_i,
  output reg [7:0] rd_data_o
);
  // Two quads of 256 bytes each; the top address bit picks the quad.
  reg [7:0] mem [0:511];

  // Writes and registered reads; read data lag the address by one cycle.
  always @(posedge mclk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

// ---- rtl/psi_i2c_slave.v ----
// Serial slave port: address match, register pointer, reads, writes, ARA.
`timescale 1ns/100ps
`include "psi_defines.vh"
// Summary of operation
// - Base address is fixed value ORed with selects.
// - Two addresses differ only in quad-select bit.
// - Quad-select bit picks an independent register copy.
// - Byte read: pointer write, restart, one byte.
// - Byte write acked per byte; read-only untouched.
// - Two-byte reads only for measurement ranges.
// - Two-byte read sends low byte then high.
// - STOP returns pointer to interrupt register.
// - Broadcast address acts as own address.
// - Alert address answered only while interrupt driven.
// - Alert reply is address with low bit one.
// - Alert reply abandoned on lost bit.
// - Winner releases interrupt; losers keep driving.
// - Winner silent to alert reads until events clear.
module psi_i2c_slave (
  input wire mclk_i,
  input wire sys_rst_i,
  input wire scl_i,              // Serial clock pin from the master.
  input wire sda_i,              // Serial data in pin.
  output wire sda_o,             // Serial data out level, always low.
  output reg sda_oe_o,           // High while pulling data out low.
  input wire [3:0] addr_sel_i,   // Address-select pins, bits 4..1.
  input wire event_pending_i,    // Core has uncleared events.
  output wire interrupt_request_n_o,  // Interrupt line level, low.
  output reg interrupt_request_oe_o,  // High while driving interrupt.
  output reg reg_wr_o,           // One-cycle pulse per accepted write.
  output reg reg_quad_o,         // Quad of the written register.
  output reg [7:0] reg_addr_o,   // Offset of the written register.
  output reg [7:0] reg_data_o,   // Value written.
  input wire core_wr_i,          // Core update of a status register.
  input wire core_quad_i,
  input wire [7:0] core_addr_i,
  input wire [7:0] core_data_i,
  output wire core_ack_o         // Core update taken this cycle.
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_REG = 3'h2;
  localparam ST_WDAT = 3'h3;
  localparam ST_ACK = 3'h4;
  localparam ST_TX = 3'h5;
  localparam ST_MACK = 3'h6;
  localparam ST_IGN = 3'h7;

  // True for offsets that software may write; all others are read-only.
  function writable;
    input [7:0] a;
    begin
      writable = (a == `PSI_REG_INTMASK) || (a == `PSI_REG_CONFIG) ||
        (a == `PSI_REG_PBGLOBAL) ||
        ((a[7:4] >= `PSI_PORT_LO) && (a[7:4] <= `PSI_PORT_HI) &&
         (a[3:0] >= `PSI_PWR_LO) && (a[3:0] <= `PSI_PWR_HI));
    end
  endfunction

  // True for offsets inside the per-port measurement ranges.
  function is_meas;
    input [7:0] a;
    begin
      is_meas = (a[7:4] >= `PSI_PORT_LO) && (a[7:4] <= `PSI_PORT_HI) &&
        (a[3:0] >= `PSI_MEAS_LO) && (a[3:0] <= `PSI_MEAS_HI);
    end
  endfunction

  // Two-stage synchronisers; only the second stage and its one-cycle-old copy feed any logic.
  reg scl_s1_r, scl_s2_r, scl_d_r;
  reg sda_s1_r, sda_s2_r, sda_d_r;
  reg [3:0] sel_s1_r, sel_s2_r;

  reg [2:0] st_r;        // Protocol state.
  reg [2:0] nxt_r;       // State to enter after an acknowledge slot.
  reg [3:0] cnt_r;       // Bits received or sent in the current byte.
  reg [7:0] sh_r;        // Shift register for both directions.
  reg txbit_r;           // Bit currently presented on the bus.
  reg [7:0] ptr_r;       // Register pointer.
  reg quad_r;            // Quad addressed by the current transaction.
  reg ara_r;             // Current read is an alert response.
  reg second_r;          // Second byte of a two-byte read is under way.
  reg won_r;             // Alert arbitration won, events not yet cleared.
  wire [7:0] rd_data;
  wire scl_rise, scl_fall, start_det, stop_det;
  wire [6:0] base_addr;
  wire [7:0] tx_byte;

  // Pin synchronisers and one-cycle-old copies for edge detection.
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r <= 1'b1;
      sel_s1_r <= 4'h0;
      sel_s2_r <= 4'h0;
    end else begin
      scl_s1_r <= scl_i;
      scl_s2_r <= scl_s1_r;
      scl_d_r <= scl_s2_r;
      sda_s1_r <= sda_i;
      sda_s2_r <= sda_s1_r;
      sda_d_r <= sda_s2_r;
      sel_s1_r <= addr_sel_i;
      sel_s2_r <= sel_s1_r;
    end
  end

  assign scl_rise = scl_s2_r & ~scl_d_r;
  assign scl_fall = ~scl_s2_r & scl_d_r;
  // Data edges while the clock stays high mark START and STOP.
  assign start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  assign stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
  assign base_addr = `PSI_ADDR_BASE | {2'b00, sel_s2_r, 1'b0};
  // The alert reply carries the first quad's address and a one below.
  assign tx_byte = ara_r ? {base_addr, 1'b1} : rd_data;
  assign sda_o = 1'b0;
  // Open drain: the pin reads low whenever the enable is high.
  assign interrupt_request_n_o = 1'b0;

  // Interrupt drive follows pending events unless arbitration was won.
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      interrupt_request_oe_o <= 1'b0;
    end else begin
      interrupt_request_oe_o <= event_pending_i & ~won_r;
    end
  end

  // Main protocol engine; STOP and START override every state.
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_r <= ST_IDLE;
      nxt_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      txbit_r <= 1'b1;
      ptr_r <= `PSI_REG_INT;
      quad_r <= 1'b0;
      ara_r <= 1'b0;
      second_r <= 1'b0;
      won_r <= 1'b0;
      sda_oe_o <= 1'b0;
      reg_wr_o <= 1'b0;
      reg_quad_o <= 1'b0;
      reg_addr_o <= 8'h00;
      reg_data_o <= 8'h00;
    end else begin
      reg_wr_o <= 1'b0;
      // Cleared events free the winner; a fresh win in the same cycle
      // overrides the clear, since its assignment comes later.
      if (~event_pending_i) begin
        won_r <= 1'b0;
      end
      if (stop_det) begin
        st_r <= ST_IDLE;
        ptr_r <= `PSI_REG_INT;
        sda_oe_o <= 1'b0;
      end else if (start_det) begin
        // A repeated START keeps the pointer for the read that follows.
        st_r <= ST_ADDR;
        cnt_r <= 4'h0;
        sda_oe_o <= 1'b0;
      end else begin
        case (st_r)
          ST_ADDR, ST_REG, ST_WDAT: begin
            if (scl_rise && cnt_r != `PSI_BITS_BYTE) begin
              sh_r <= {sh_r[6:0], sda_s2_r};
              cnt_r <= cnt_r + 4'h1;
            end else if (scl_fall && cnt_r == `PSI_BITS_BYTE) begin
              cnt_r <= 4'h0;
              if (st_r == ST_ADDR) begin
                ara_r <= 1'b0;
                second_r <= 1'b0;
                if (sh_r[7:1] == (base_addr | {6'h00, sh_r[1]})) begin
                  // Either quad address; its low bit names the copy.
                  quad_r <= sh_r[1];
                  nxt_r <= sh_r[0] ? ST_TX : ST_REG;
                  sda_oe_o <= 1'b1;
                  st_r <= ST_ACK;
                end else if (sh_r[7:1] == `PSI_ADDR_BCAST) begin
                  quad_r <= 1'b0;
                  nxt_r <= sh_r[0] ? ST_TX : ST_REG;
                  sda_oe_o <= 1'b1;
                  st_r <= ST_ACK;
                end else if (sh_r[7:1] == `PSI_ADDR_ARA && sh_r[0] &&
                             interrupt_request_oe_o) begin
                  ara_r <= 1'b1;
                  nxt_r <= ST_TX;
                  sda_oe_o <= 1'b1;
                  st_r <= ST_ACK;
                end else begin
                  st_r <= ST_IGN;
                end
              end else if (st_r == ST_REG) begin
                ptr_r <= sh_r;
                nxt_r <= ST_WDAT;
                sda_oe_o <= 1'b1;
                st_r <= ST_ACK;
              end else begin
                // Every data byte is acked; read-only targets are dropped.
                reg_wr_o <= writable(ptr_r);
                reg_quad_o <= quad_r;
                reg_addr_o <= ptr_r;
                reg_data_o <= sh_r;
                ptr_r <= ptr_r + 8'h01;
                nxt_r <= ST_WDAT;
                sda_oe_o <= 1'b1;
                st_r <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              st_r <= nxt_r;
              if (nxt_r == ST_TX) begin
                // First data bit goes out on the same falling edge.
                sh_r <= tx_byte;
                txbit_r <= tx_byte[7];
                sda_oe_o <= ~tx_byte[7];
              end else begin
                sda_oe_o <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_rise && ara_r && txbit_r && ~sda_s2_r) begin
              // Someone else drove a zero over our one: back off.
              sda_oe_o <= 1'b0;
              st_r <= ST_IGN;
            end else if (scl_fall) begin
              if (cnt_r == `PSI_BIT_LAST) begin
                sda_oe_o <= 1'b0;
                st_r <= ST_MACK;
                if (ara_r) begin
                  won_r <= 1'b1;
                end
              end else begin
                cnt_r <= cnt_r + 4'h1;
                sh_r <= {sh_r[6:0], 1'b0};
                txbit_r <= sh_r[6];
                sda_oe_o <= ~sh_r[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              cnt_r <= 4'h0;
              // Only a measurement low byte may be followed by its high.
              if (~sda_s2_r && ~ara_r && ~second_r && is_meas(ptr_r) &&
                  ptr_r[3:0] != `PSI_MEAS_HI) begin
                ptr_r <= ptr_r + 8'h01;
                second_r <= 1'b1;
                nxt_r <= ST_TX;
                st_r <= ST_ACK;
              end else begin
                // NACK ends the read; any other ack gets no more data.
                st_r <= ST_IGN;
              end
            end
          end
          ST_IGN: begin
            sda_oe_o <= 1'b0;
          end
          default: begin
            st_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Host writes take the store first; core updates wait a cycle then.
  assign core_ack_o = core_wr_i & ~reg_wr_o;

  psi_regmem u_mem (
    .mclk_i(mclk_i),
    .wr_en_i(reg_wr_o | core_wr_i),
    .wr_addr_i(reg_wr_o ? {reg_quad_o, reg_addr_o} :
                          {core_quad_i, core_addr_i}),
    .wr_data_i(reg_wr_o ? reg_data_o : core_data_i),
    .rd_addr_i({quad_r, ptr_r}),
    .rd_data_o(rd_data)
  );
endmodule

// ---- tb/psi_i2c_slave_assertions.sv ----
// Concurrent checks on the pins of the serial slave port.
`timescale 1ns/100ps
module psi_i2c_slave_assertions (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_oe_o,
  input wire logic event_pending_i,
  input wire logic interrupt_request_oe_o,
  input wire logic reg_wr_o,
  input wire logic [7:0] reg_addr_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // Offsets that accept writes: three globals, the strobe and config rows.
  wire wr_ok = reg_addr_o == 8'h01 || reg_addr_o == 8'h0a ||
    reg_addr_o == 8'h0b || (reg_addr_o[7:4] >= 4'h1 &&
    reg_addr_o[7:4] <= 4'h4 && reg_addr_o[3:2] == 2'h1);
  // A driven slot holds for at least four cycles, one clock phase.
  sequence s_slot;
    sda_oe_o [*4];
  endsequence
  // The interrupt line goes active on the next edge.
  sequence s_irq_on;
    ##1 interrupt_request_oe_o;
  endsequence
  a_rst_quiet: assert property (disable iff (1'b0)
    sys_rst_i |=> !sda_oe_o && !reg_wr_o && !interrupt_request_oe_o)
    else $error("outputs active after reset");
  a_wr_pulse: assert property (reg_wr_o |=> !reg_wr_o)
    else $error("write strobe longer than one cycle");
  a_wr_legal: assert property (reg_wr_o |-> wr_ok)
    else $error("write strobe for a read-only offset");
  a_wr_clk_low: assert property (reg_wr_o |-> !scl_i)
    else $error("write strobe while serial clock high");
  a_oe_clk_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data drive changed while serial clock high");
  a_oe_hold: assert property ($rose(sda_oe_o) |-> s_slot)
    else $error("data drive shorter than a slot");
  a_irq_off: assert property (!event_pending_i |=>
    !interrupt_request_oe_o)
    else $error("interrupt driven without pending events");
  a_irq_rise: assert property ($rose(event_pending_i) |-> s_irq_on)
    else $error("interrupt not driven for new events");
endmodule

// ---- tb/psi_host_model.sv ----
// Bus master model: drives the serial clock and its own data level.
`timescale 1ns/100ps
module psi_host_model (
  input wire logic mclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  // Both lines idle high; the clock stands still between frames.
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // A half bit is four system clocks, a 200 ns serial period.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    tick(1);
    sda_o <= 1'b1;
    tick(4);
    scl_o <= 1'b1;
    tick(4);
    sda_o <= 1'b0;
    tick(4);
    scl_o <= 1'b0;
  endtask
  // Stop: data rises while the clock is high, then the bus is free.
  task automatic stop();
    tick(1);
    sda_o <= 1'b0;
    tick(4);
    scl_o <= 1'b1;
    tick(4);
    sda_o <= 1'b1;
    tick(4);
  endtask
  // Data moves one edge after the clock falls, never with it.
  task automatic bit_slot(input logic b, output logic r);
    tick(1);
    sda_o <= b;
    tick(3);
    scl_o <= 1'b1;
    tick(4);
    r = sda_i;
    scl_o <= 1'b0;
  endtask
  // Eight bits then the ninth slot; a one there releases the line.
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i], q[i]);
    end
    bit_slot(a, ack);
  endtask
endmodule

// ---- tb/psi_i2c_slave_tb.sv ----
// Self-checking bench for the serial slave port.
`timescale 1ns/100ps
module psi_i2c_slave_tb;
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, event_pending_i = 1'b0;
  logic core_wr_i = 1'b0, core_quad_i = 1'b0, rival = 1'b0;
  logic [7:0] core_addr_i = 8'h00, core_data_i = 8'h00, q;
  logic [3:0] addr_sel_i = 4'h3;
  logic scl_i, sda_m, sda_o, sda_oe_o, interrupt_request_n_o, k;
  logic interrupt_request_oe_o, reg_wr_o, reg_quad_o, core_ack_o;
  logic [7:0] reg_addr_o, reg_data_o;
  logic [16:0] last_wr;
  int n_mismatch = 0, checked = 0, n_wr = 0;
  // Open-drain data line with a pull-up; any party may pull it low.
  wire sda_i = sda_m & ~sda_oe_o & ~rival;
  always #12.5 mclk_i = ~mclk_i;
  psi_host_model h (.mclk_i, .sda_i, .scl_o(scl_i), .sda_o(sda_m));
  psi_i2c_slave dut (.mclk_i, .sys_rst_i, .scl_i, .sda_i, .sda_o,
    .sda_oe_o, .addr_sel_i, .event_pending_i, .interrupt_request_n_o,
    .interrupt_request_oe_o, .reg_wr_o, .reg_quad_o, .reg_addr_o,
    .reg_data_o, .core_wr_i, .core_quad_i, .core_addr_i, .core_data_i,
    .core_ack_o);
  // Record every accepted register write.
  always @(posedge mclk_i) begin
    if (reg_wr_o === 1'b1) begin
      n_wr <= n_wr + 1;
      last_wr <= {reg_quad_o, reg_addr_o, reg_data_o};
    end
  end
  task automatic check(input logic [16:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Start, then the address byte and its acknowledge slot.
  task automatic head(input logic [7:0] a, input logic ackx);
    h.start();
    h.xfer(a, 1'b1, q, k);
    check(k, ackx);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] r, d);
    head({a, 1'b0}, 1'b0);
    h.xfer(r, 1'b1, q, k);
    h.xfer(d, 1'b1, q, k);
    check(k, 1'b0);
    h.stop();
  endtask
  // Pointer write, restart, one or two bytes back, the low one first.
  task automatic rd(input logic [6:0] a, input logic [7:0] r,
                    input logic two, input logic [15:0] exp);
    logic [7:0] lo;
    head({a, 1'b0}, 1'b0);
    h.xfer(r, 1'b1, q, k);
    head({a, 1'b1}, 1'b0);
    h.xfer(8'hff, ~two, lo, k);
    if (two) h.xfer(8'hff, 1'b1, q, k);
    h.stop();
    check({two ? q : 8'h00, lo}, exp);
  endtask
  // A read with no pointer write lands on the interrupt register.
  task automatic quick(input logic [6:0] a, input logic [7:0] exp);
    head({a, 1'b1}, 1'b0);
    h.xfer(8'hff, 1'b1, q, k);
    h.stop();
    check(q, exp);
  endtask
  task automatic core(input logic qd, input logic [7:0] a, d);
    core_quad_i <= qd;
    core_addr_i <= a;
    core_data_i <= d;
    core_wr_i <= 1'b1;
    @(posedge mclk_i);
    // No host write is under way, so the store takes the update now.
    check(core_ack_o, 1'b1);
    core_wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic t_rw();
    int w;
    wr(7'h26, 8'h01, 8'h5a);
    check(last_wr, {1'b0, 8'h01, 8'h5a});
    wr(7'h27, 8'h01, 8'ha5);
    check(last_wr, {1'b1, 8'h01, 8'ha5});
    w = n_wr;
    wr(7'h26, 8'h00, 8'hff);
    check(17'(n_wr - w), 17'h0);
    rd(7'h26, 8'h01, 1'b0, 16'h005a);
    rd(7'h27, 8'h01, 1'b0, 16'h00a5);
    $display("test rw done");
  endtask
  task automatic t_rd();
    core(1'b1, 8'h2a, 8'h34);
    core(1'b1, 8'h2b, 8'h12);
    rd(7'h27, 8'h2a, 1'b1, 16'h1234);
    rd(7'h26, 8'h01, 1'b1, 16'hff5a);
    // The last offset of a measurement row has no high byte after it.
    core(1'b0, 8'h2c, 8'h77);
    rd(7'h26, 8'h2c, 1'b1, 16'hff77);
    core(1'b0, 8'h00, 8'h81);
    core(1'b1, 8'h00, 8'h18);
    quick(7'h26, 8'h81);
    quick(7'h27, 8'h18);
    $display("test rd done");
  endtask
  task automatic t_addr();
    wr(7'h40, 8'h0a, 8'h3c);
    check(last_wr, {1'b0, 8'h0a, 8'h3c});
    head(8'h66, 1'b1);
    h.stop();
    head(8'h19, 1'b1);
    h.stop();
    // Other select pins move the address; the old one must go quiet.
    addr_sel_i <= 4'ha;
    wr(7'h35, 8'h0b, 8'h11);
    check(last_wr, {1'b1, 8'h0b, 8'h11});
    head(8'h4c, 1'b1);
    h.stop();
    addr_sel_i <= 4'h3;
    $display("test addr done");
  endtask
  // A rival holds the line low and wins; then our reply goes through.
  task automatic t_ara();
    event_pending_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    check(interrupt_request_oe_o, 1'b1);
    // Both open-drain lines show a low level whenever they are enabled.
    check({sda_o, interrupt_request_n_o}, 2'h0);
    head(8'h19, 1'b0);
    @(posedge mclk_i);
    rival <= 1'b1;
    h.xfer(8'hff, 1'b1, q, k);
    @(posedge mclk_i);
    rival <= 1'b0;
    h.stop();
    check({q, interrupt_request_oe_o}, {8'h00, 1'b1});
    head(8'h19, 1'b0);
    h.xfer(8'hff, 1'b1, q, k);
    h.stop();
    check({q, interrupt_request_oe_o}, {8'h4d, 1'b0});
    head(8'h19, 1'b1);
    h.stop();
    event_pending_i <= 1'b0;
    $display("test ara done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    t_rw();
    t_rd();
    t_addr();
    t_ara();
    finish_test();
  end
  // The tests need well under 10000 cycles; this cuts a hang short.
  initial begin
    repeat (40000) @(posedge mclk_i);
    n_mismatch++;
    finish_test();
  end
endmodule
bind psi_i2c_slave psi_i2c_slave_assertions chk (.mclk_i, .sys_rst_i,
  .scl_i, .sda_oe_o, .event_pending_i, .interrupt_request_oe_o,
  .reg_wr_o, .reg_addr_o);
